/* pkg/sea_defs.svh */
`ifndef SEA_DEFS_SVH
`define SEA_DEFS_SVH
// Overview of operation
// RQ1: memory reached by serial clock and data
// RQ2: memory holds 512 eight-bit locations
// RQ3: fetching starts only after reset release
// RQ4: 16-bit words, 7-bit word address
// RQ5: chip-select address bits always zero
// RQ6: sequencer does single word software transfers
// RQ7: software gives start, address, read/write
// RQ8: software checks status before each start
// RQ9: word zero must match signature first
// RQ10: load consecutive words into mapped registers
// RQ11: status bit 3 at DCh high while loading
// RQ12: ids and port settings from fixed words
// RQ13: bad signature skips load, reports complete

// signature word, value is arbitrary
`define SEA_SIG_VALUE   16'h5AC3
`define SEA_SIG_ADDR    7'h00
`define SEA_FIRST_WORD  7'h01
`define SEA_LAST_WORD   7'h0F
`define SEA_MEM_BYTES   512
// word index of each mapped register
`define SEA_W_VENDOR    4'h1
`define SEA_W_DEVICE    4'h2
`define SEA_W_PORTCFG   4'h3
`define SEA_W_SSVENDOR  4'h4
`define SEA_W_SSID      4'h5
`define SEA_CFG_DEFAULT 16'h0000
// status register at offset DCh, bit 3
`define SEA_DCH_OFFSET  8'hDC
`define SEA_AL_BIT      3
// control byte: type code, chip select, page bit
`define SEA_CTRL_TYPE   4'hA
`define SEA_CS_BITS     2'h0
`define SEA_PAGE_BIT    1'h0
`define SEA_RD_LAST_IX  3'h4
`define SEA_WR_LAST_IX  3'h3
`define SEA_RESTART_IX  3'h2
// serial clock quarter period on the link clock, about 1 MHz bit rate
// keeps a full sixteen-word load short enough for the bench's time budget
`define SEA_QUARTER_NS  250
`define SEA_LINK_NS     30
`define SEA_QUARTER_CYC ((`SEA_QUARTER_NS + `SEA_LINK_NS - 1) / `SEA_LINK_NS)
`define SEA_FIFO_DEPTH  16
`endif

/* pkg/sea_pkg.sv */
package sea_pkg;
  typedef struct packed {
    logic        wr;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } sea_cmd_s;
  typedef struct packed {
    logic        nack;
    logic [15:0] rdata;
  } sea_rsp_s;
  typedef struct packed {
    logic [3:0]  idx;
    logic [15:0] data;
  } sea_cfgw_s;
  typedef enum logic [6:0] {
    C_SIG_REQ  = 7'h01,
    C_SIG_WAIT = 7'h02,
    C_LD_REQ   = 7'h04,
    C_LD_WAIT  = 7'h08,
    C_LD_DRAIN = 7'h10,
    C_READY    = 7'h20,
    C_SW_WAIT  = 7'h40
  } sea_core_e;
  typedef enum logic [3:0] {
    L_IDLE  = 4'h1,
    L_START = 4'h2,
    L_BYTE  = 4'h4,
    L_STOP  = 4'h8
  } sea_link_e;
endpackage

/* hdl/sea_top.sv */
`timescale 1ns/10ps
`include "sea_defs.svh"

// ----------------------------------------
// word fifo between link results and registers
// ----------------------------------------
module sea_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [CW-1:0]    cnt_ff;
  logic             push;
  logic             pop;

  // handshake terms
  assign o_in_ready  = (cnt_ff != CW'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data  = mem_ff[rp_ff];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // storage write
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_ff[wp_ff] <= i_in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop)
      begin
        rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end
endmodule

// ----------------------------------------
// loader, sequencer and serial link engine
// ----------------------------------------
module sea_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_link_clk,
  input  wire logic        i_cfgmem_serial_data_in,
  output logic             o_cfgmem_serial_clock_out,
  output logic             o_cfgmem_serial_data_out,
  output logic             o_cfgmem_serial_data_oe_n,
  input  wire logic        i_sw_start,
  input  wire logic        i_sw_write,
  input  wire logic [6:0]  i_sw_addr,
  input  wire logic [15:0] i_sw_wdata,
  output logic [15:0]      o_sw_rdata,
  output logic             o_sw_nack,
  output logic [7:0]       o_cfg_dch,
  output logic             o_sig_ok,
  input  wire logic        i_cfg_wr_ready,
  output logic             o_cfg_wr_valid,
  output logic [3:0]       o_cfg_wr_idx,
  output logic [15:0]      o_cfg_wr_data,
  output logic [15:0]      o_vendor_id,
  output logic [15:0]      o_device_id,
  output logic [15:0]      o_port_cfg,
  output logic [15:0]      o_subsys_vendor_id,
  output logic [15:0]      o_subsys_id
);
  localparam logic [7:0] QCYC = 8'(`SEA_QUARTER_CYC);

  // ----------------------------------------
  // core domain
  // ----------------------------------------
  sea_pkg::sea_core_e state_ff;
  sea_pkg::sea_cmd_s  cmd_ff;
  sea_pkg::sea_rsp_s  rsp_l_ff;
  sea_pkg::sea_cfgw_s fifo_in;
  sea_pkg::sea_cfgw_s fifo_out;
  logic        req_tgl_ff;
  logic [2:0]  ack_sync_ff;
  logic        ack_ev;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        sig_ok_ff;
  logic [15:0] cfg_mem_ff [16];
  logic        ack_tgl_ff;

  // ack toggle from link: two flops, then edge compare
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ack_sync_ff <= '0;
    end
    else
    begin
      ack_sync_ff <= {ack_sync_ff[1:0], ack_tgl_ff};
    end
  end
  assign ack_ev = ack_sync_ff[2] ^ ack_sync_ff[1];

  // loader and sequencer state
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state_ff   <= sea_pkg::C_SIG_REQ; // see RQ3
      cmd_ff     <= '0;
      req_tgl_ff <= 1'b0;
      sig_ok_ff  <= 1'b0;
    end
    else
    begin
      case (state_ff)
        sea_pkg::C_SIG_REQ:
        begin
          cmd_ff     <= '{wr: 1'b0, addr: `SEA_SIG_ADDR, wdata: 16'h0000}; // see RQ9
          req_tgl_ff <= ~req_tgl_ff;
          state_ff   <= sea_pkg::C_SIG_WAIT;
        end
        sea_pkg::C_SIG_WAIT:
        begin
          if (ack_ev)
          begin
            if (!rsp_l_ff.nack && rsp_l_ff.rdata == `SEA_SIG_VALUE) // see RQ9
            begin
              sig_ok_ff   <= 1'b1;
              cmd_ff.addr <= `SEA_FIRST_WORD;
              state_ff    <= sea_pkg::C_LD_REQ;
            end
            else
            begin
              state_ff <= sea_pkg::C_READY; // see RQ13
            end
          end
        end
        sea_pkg::C_LD_REQ:
        begin
          if (fifo_in_ready) // stall while the fifo is full
          begin
            req_tgl_ff <= ~req_tgl_ff;
            state_ff   <= sea_pkg::C_LD_WAIT;
          end
        end
        sea_pkg::C_LD_WAIT:
        begin
          if (ack_ev)
          begin
            if (rsp_l_ff.nack || cmd_ff.addr == `SEA_LAST_WORD)
            begin
              state_ff <= sea_pkg::C_LD_DRAIN;
            end
            else
            begin
              cmd_ff.addr <= cmd_ff.addr + 7'h01; // see RQ10
              state_ff    <= sea_pkg::C_LD_REQ;
            end
          end
        end
        sea_pkg::C_LD_DRAIN:
        begin
          if (!fifo_out_valid)
          begin
            state_ff <= sea_pkg::C_READY; // see RQ11
          end
        end
        sea_pkg::C_READY:
        begin
          if (i_sw_start) // see RQ6, RQ7
          begin
            cmd_ff     <= '{wr: i_sw_write, addr: i_sw_addr, wdata: i_sw_wdata};
            req_tgl_ff <= ~req_tgl_ff;
            state_ff   <= sea_pkg::C_SW_WAIT;
          end
        end
        sea_pkg::C_SW_WAIT:
        begin
          if (ack_ev)
          begin
            state_ff <= sea_pkg::C_READY;
          end
        end
        default:
        begin
          state_ff <= sea_pkg::C_READY;
        end
      endcase
    end
  end

  // software result capture
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_sw_rdata <= 16'h0000;
      o_sw_nack  <= 1'b0;
    end
    else if (state_ff == sea_pkg::C_SW_WAIT && ack_ev)
    begin
      o_sw_rdata <= cmd_ff.wr ? o_sw_rdata : rsp_l_ff.rdata;
      o_sw_nack  <= rsp_l_ff.nack;
    end
  end

  // each loaded word enters the fifo with its register index
  assign fifo_in_valid = (state_ff == sea_pkg::C_LD_WAIT) && ack_ev && !rsp_l_ff.nack;
  assign fifo_in.idx   = cmd_ff.addr[3:0];
  assign fifo_in.data  = rsp_l_ff.rdata;

  sea_fifo #(
    .WIDTH ($bits(sea_pkg::sea_cfgw_s)),
    .DEPTH (`SEA_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (i_cfg_wr_ready),
    .o_out_data  (fifo_out)
  );

  // drain into the register words and the write stream
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < 16; i++)
      begin
        cfg_mem_ff[i] <= `SEA_CFG_DEFAULT; // see RQ13
      end
      o_cfg_wr_valid <= 1'b0;
      o_cfg_wr_idx   <= 4'h0;
      o_cfg_wr_data  <= 16'h0000;
    end
    else
    begin
      o_cfg_wr_valid <= fifo_out_valid && i_cfg_wr_ready;
      if (fifo_out_valid && i_cfg_wr_ready)
      begin
        cfg_mem_ff[fifo_out.idx] <= fifo_out.data; // see RQ10
        o_cfg_wr_idx             <= fifo_out.idx;
        o_cfg_wr_data            <= fifo_out.data;
      end
    end
  end

  // mapped register words
  assign o_vendor_id        = cfg_mem_ff[`SEA_W_VENDOR]; // see RQ12
  assign o_device_id        = cfg_mem_ff[`SEA_W_DEVICE];
  assign o_port_cfg         = cfg_mem_ff[`SEA_W_PORTCFG];
  assign o_subsys_vendor_id = cfg_mem_ff[`SEA_W_SSVENDOR];
  assign o_subsys_id        = cfg_mem_ff[`SEA_W_SSID];
  assign o_sig_ok           = sig_ok_ff;

  // status byte: busy bit high until load or access ends
  always_comb
  begin
    o_cfg_dch             = 8'h00;
    o_cfg_dch[`SEA_AL_BIT] = (state_ff != sea_pkg::C_READY); // see RQ11, RQ8
  end

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  sea_pkg::sea_link_e lst_ff;
  sea_pkg::sea_cmd_s  cmd_l_ff;
  logic [1:0] rst_l_ff;
  logic [2:0] req_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [7:0] div_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_ff;
  logic [2:0] ix_ff;
  logic [7:0] sh_ff;
  logic       scl_ff;
  logic       low_ff;
  logic       tick;
  logic       rx;
  logic [2:0] last_ix;

  // byte sent at each position of a transfer
  function automatic logic [7:0] tx_byte(input sea_pkg::sea_cmd_s c, input logic [2:0] ix);
    logic [7:0] ctl;
    ctl = {`SEA_CTRL_TYPE, `SEA_CS_BITS, `SEA_PAGE_BIT, 1'b0}; // see RQ5, RQ2
    case (ix)
      3'h0:    tx_byte = ctl;
      3'h1:    tx_byte = {c.addr, 1'b0}; // see RQ4
      3'h2:    tx_byte = c.wr ? c.wdata[7:0] : (ctl | 8'h01);
      3'h3:    tx_byte = c.wdata[15:8];
      default: tx_byte = 8'h00;
    endcase
  endfunction

  // reset and request toggle synchronisers
  always_ff @(posedge i_link_clk)
  begin
    rst_l_ff    <= {rst_l_ff[0], i_rst};
    req_sync_ff <= {req_sync_ff[1:0], req_tgl_ff};
    sda_sync_ff <= {sda_sync_ff[0], i_cfgmem_serial_data_in};
  end

  assign tick    = (div_ff == QCYC - 8'h01);
  assign rx      = !cmd_l_ff.wr && (ix_ff >= 3'h3);
  assign last_ix = cmd_l_ff.wr ? `SEA_WR_LAST_IX : `SEA_RD_LAST_IX;

  // quarter bit divider
  always_ff @(posedge i_link_clk)
  begin
    if (rst_l_ff[1] || lst_ff == sea_pkg::L_IDLE || tick)
    begin
      div_ff <= 8'h00;
    end
    else
    begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // serial engine: start, bytes with acknowledge, stop
  always_ff @(posedge i_link_clk)
  begin
    if (rst_l_ff[1])
    begin
      lst_ff     <= sea_pkg::L_IDLE;
      cmd_l_ff   <= '0;
      q_ff       <= 2'h0;
      bit_ff     <= 4'h0;
      ix_ff      <= 3'h0;
      sh_ff      <= 8'h00;
      scl_ff     <= 1'b1;
      low_ff     <= 1'b0;
      rsp_l_ff   <= '0;
      ack_tgl_ff <= 1'b0;
    end
    else
    begin
      case (lst_ff)
        sea_pkg::L_IDLE:
        begin
          q_ff <= 2'h0;
          if (req_sync_ff[2] ^ req_sync_ff[1])
          begin
            cmd_l_ff      <= cmd_ff; // stable while the request is open
            sh_ff         <= tx_byte(cmd_ff, 3'h0);
            ix_ff         <= 3'h0;
            rsp_l_ff.nack <= 1'b0;
            lst_ff        <= sea_pkg::L_START;
          end
        end
        sea_pkg::L_START:
        begin
          if (tick)
          begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0:    begin scl_ff <= 1'b0; low_ff <= 1'b0; end
              2'h1:    scl_ff <= 1'b1;
              2'h2:    low_ff <= 1'b1;
              default:
              begin
                scl_ff <= 1'b0;
                bit_ff <= 4'h0;
                lst_ff <= sea_pkg::L_BYTE;
              end
            endcase
          end
        end
        sea_pkg::L_BYTE:
        begin
          if (tick)
          begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0:
              begin
                if (bit_ff != 4'h8)
                begin
                  low_ff <= !rx && !sh_ff[7];
                end
                else
                begin
                  low_ff <= rx && (ix_ff != last_ix);
                end
              end
              2'h1:    scl_ff <= 1'b1;
              2'h2:
              begin
                if (bit_ff != 4'h8)
                begin
                  sh_ff <= {sh_ff[6:0], sda_sync_ff[1]};
                end
                else if (!rx && sda_sync_ff[1])
                begin
                  rsp_l_ff.nack <= 1'b1;
                end
              end
              default:
              begin
                scl_ff <= 1'b0;
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == 4'h8)
                begin
                  bit_ff <= 4'h0;
                  ix_ff  <= ix_ff + 3'h1;
                  sh_ff  <= tx_byte(cmd_l_ff, ix_ff + 3'h1);
                  if (rx && ix_ff == 3'h3)
                  begin
                    rsp_l_ff.rdata[7:0] <= sh_ff;
                  end
                  if (rx && ix_ff == 3'h4)
                  begin
                    rsp_l_ff.rdata[15:8] <= sh_ff;
                  end
                  if (rsp_l_ff.nack || ix_ff == last_ix)
                  begin
                    lst_ff <= sea_pkg::L_STOP;
                  end
                  else if (!cmd_l_ff.wr && ix_ff + 3'h1 == `SEA_RESTART_IX)
                  begin
                    lst_ff <= sea_pkg::L_START;
                  end
                end
              end
            endcase
          end
        end
        sea_pkg::L_STOP:
        begin
          if (tick)
          begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0:    low_ff <= 1'b1;
              2'h1:    scl_ff <= 1'b1;
              2'h2:    low_ff <= 1'b0;
              default:
              begin
                ack_tgl_ff <= ~ack_tgl_ff;
                lst_ff     <= sea_pkg::L_IDLE;
              end
            endcase
          end
        end
        default:
        begin
          lst_ff <= sea_pkg::L_IDLE;
        end
      endcase
    end
  end

  // open-drain data: enable low pulls the line low
  assign o_cfgmem_serial_clock_out = scl_ff; // see RQ1
  assign o_cfgmem_serial_data_out  = 1'b0;
  assign o_cfgmem_serial_data_oe_n = ~low_ff;
endmodule

/* test/sea_eeprom_model.sv */
`timescale 1ns/10ps

// ----------------------------------------
// two-wire memory model, data line pulled up
// ----------------------------------------
module sea_eeprom_model (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_oe_n
);
  logic [7:0] mem [0:511];
  logic [7:0] sh;
  logic [8:0] ptr;
  logic [3:0] bitn;
  logic [1:0] ph;
  logic       act;
  logic       mack;
  logic       rdb;

  initial
  begin
    act = 1'b0;
    o_sda_oe_n = 1'b1;
  end

  // start or repeated start while the clock is high
  always @(negedge i_sda)
    if (i_scl)
    begin
      act = 1'b1;
      bitn = 4'hF;  // the start's own falling clock brings it to zero
      ph = 2'h0;
      mack = 1'b0;
    end

  // stop ends the frame
  always @(posedge i_sda)
    if (i_scl)
      act = 1'b0;

  // shift in bits, take the host acknowledge
  always @(posedge i_scl)
    if (act && bitn < 4'h8)
      sh = {sh[6:0], i_sda};
    else if (act)
      mack = i_sda;

  // falling clock: acknowledge, store, or shift out
  always @(negedge i_scl)
    if (act)
    begin
      o_sda_oe_n = 1'b1;
      if (bitn == 4'h7)
      begin
        bitn = 4'h8;
        rdb = (ph == 2'h3);
        case (ph)
          2'h0:
          begin
            act = (sh[7:4] == 4'hA) && (sh[3:2] == 2'h0);
            ptr[8] = sh[1];
            ph = sh[0] ? 2'h3 : 2'h1;
          end
          2'h1:
          begin
            ptr[7:0] = sh;
            ph = 2'h2;
          end
          2'h2:
          begin
            mem[ptr] = sh;
            ptr[3:0] = ptr[3:0] + 4'h1;
          end
          default:
            ptr = ptr + 9'h001;
        endcase
        o_sda_oe_n = !act || rdb;
      end
      else if (bitn == 4'h8)
      begin
        bitn = 4'h0;
        if (ph == 2'h3 && mack)
          act = 1'b0;
        o_sda_oe_n = !(act && ph == 2'h3) || mem[ptr][7];
      end
      else
      begin
        bitn = bitn + 4'h1;
        o_sda_oe_n = (ph != 2'h3) || mem[ptr][3'(4'h7 - bitn)];
      end
    end
endmodule

/* test/sea_top_assertions.sv */
`timescale 1ns/10ps
`include "sea_defs.svh"

// ----------------------------------------
// port checker for the loader
// ----------------------------------------
module sea_top_assertions (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_link_clk,
  input wire logic        o_cfgmem_serial_clock_out,
  input wire logic        o_cfgmem_serial_data_out,
  input wire logic        o_cfgmem_serial_data_oe_n,
  input wire logic        i_sw_start,
  input wire logic [7:0]  o_cfg_dch,
  input wire logic        o_sig_ok,
  input wire logic        i_cfg_wr_ready,
  input wire logic        o_cfg_wr_valid,
  input wire logic [3:0]  o_cfg_wr_idx,
  input wire logic [15:0] o_cfg_wr_data,
  input wire logic [15:0] o_vendor_id,
  input wire logic [15:0] o_port_cfg
);
  logic [5:0] rst_hist_ff;
  logic [3:0] last_idx_ff;

  // reset history and last register word written
  always_ff @(posedge i_ref_clk)
    rst_hist_ff <= {rst_hist_ff[4:0], i_rst};
  always_ff @(posedge i_ref_clk)
    if (i_rst)
      last_idx_ff <= 4'h0;
    else if (o_cfg_wr_valid)
      last_idx_ff <= o_cfg_wr_idx;

  // mapped output follows the word written for its index
  property map_p(logic [3:0] ix, logic [15:0] r);
    @(posedge i_ref_clk) disable iff (i_rst)
      o_cfg_wr_valid && o_cfg_wr_idx == ix |-> r == o_cfg_wr_data;
  endproperty

  chk_quiet_in_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rst)
    &rst_hist_ff |-> o_cfgmem_serial_clock_out && o_cfgmem_serial_data_oe_n && o_cfg_dch == 8'h08)
    else $error("link not idle or status wrong in reset");
  chk_dch_spare_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_cfg_dch[7:4] == 4'h0 && o_cfg_dch[2:0] == 3'h0)
    else $error("status spare bits set");
  chk_data_low_only: assert property (@(posedge i_link_clk) disable iff (i_rst)
    !o_cfgmem_serial_data_oe_n |-> !o_cfgmem_serial_data_out)
    else $error("data line driven high");
  chk_start_busy: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_sw_start && !o_cfg_dch[3] |=> o_cfg_dch[3] [*8])
    else $error("accepted start not busy");
  chk_load_order: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_cfg_wr_valid |-> o_cfg_wr_idx == last_idx_ff + 4'h1)
    else $error("register words out of order");
  chk_load_needs_sig: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_cfg_wr_valid |-> o_sig_ok)
    else $error("load without signature");
  chk_pop_needs_ready: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_cfg_wr_valid |-> $past(i_cfg_wr_ready))
    else $error("register write while stalled");
  chk_vendor_map: assert property (map_p(`SEA_W_VENDOR, o_vendor_id))
    else $error("vendor word not mapped");
  chk_port_map: assert property (map_p(`SEA_W_PORTCFG, o_port_cfg))
    else $error("port word not mapped");

  cov_sw_start: cover property (@(posedge i_ref_clk) i_sw_start && !o_cfg_dch[3]);
  cov_cfg_write: cover property (@(posedge i_ref_clk) o_cfg_wr_valid);
  cov_load_done: cover property (@(posedge i_ref_clk) $fell(o_cfg_dch[3]));
endmodule

/* test/sea_top_test.sv */
`timescale 1ns/10ps
`include "sea_defs.svh"

// ----------------------------------------
// bench top
// ----------------------------------------
module sea_top_test;
  typedef struct packed {
    logic        wr;
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } sea_row_s;

  localparam sea_row_s ROWS [5] = '{
    '{1'b1, 7'h7F, 16'hBEEF, 16'h0000},
    '{1'b0, 7'h7F, 16'h0000, 16'hBEEF},
    '{1'b0, 7'h03, 16'h0000, 16'h3333},
    '{1'b1, 7'h10, 16'hA55A, 16'h0000},
    '{1'b0, 7'h10, 16'h0000, 16'hA55A}
  };

  logic        clk, link_clk, rst, sda, mem_oe_n, scl, sd_out, sd_oe_n;
  logic        sw_start, sw_write, nack, sig_ok, ready, wr_valid;
  logic [6:0]  sw_addr;
  logic [15:0] sw_wdata, rdata, wr_data, vid, did, pcfg, svid, sid;
  logic [7:0]  dch;
  logic [3:0]  wr_idx;
  logic [15:0] sig;
  int          mismatches, comparisons, pulses;

  assign sda = sd_oe_n & mem_oe_n;  // pull-up wins when both release

  sea_top i_sea_top (
    .i_ref_clk(clk), .i_rst(rst), .i_link_clk(link_clk),
    .i_cfgmem_serial_data_in(sda), .o_cfgmem_serial_clock_out(scl),
    .o_cfgmem_serial_data_out(sd_out), .o_cfgmem_serial_data_oe_n(sd_oe_n),
    .i_sw_start(sw_start), .i_sw_write(sw_write), .i_sw_addr(sw_addr),
    .i_sw_wdata(sw_wdata), .o_sw_rdata(rdata), .o_sw_nack(nack), .o_cfg_dch(dch),
    .o_sig_ok(sig_ok), .i_cfg_wr_ready(ready), .o_cfg_wr_valid(wr_valid),
    .o_cfg_wr_idx(wr_idx), .o_cfg_wr_data(wr_data), .o_vendor_id(vid),
    .o_device_id(did), .o_port_cfg(pcfg), .o_subsys_vendor_id(svid), .o_subsys_id(sid)
  );

  sea_eeprom_model i_sea_eeprom_model (
    .i_scl(scl),
    .i_sda(sda),
    .o_sda_oe_n(mem_oe_n)
  );

  // clocks, link clock off in phase
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (dch[3] !== 1'b0 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (n == lim)
    begin
      mismatches++;
      final_report;
    end
  endtask

  task automatic sw_go(input sea_row_s r);
    @(negedge clk);
    sw_start = 1'b1;
    sw_write = r.wr;
    sw_addr = r.addr;
    sw_wdata = r.wdata;
    @(negedge clk);
    sw_start = 1'b0;
  endtask

  // every register word written must be the memory word
  always @(negedge clk)
    if (wr_valid === 1'b1)
    begin
      pulses++;
      check("cfg word", wr_data, 16'h1111 * {12'h000, wr_idx});
    end

  // main sequence
  initial
  begin
    rst = 1'b1;
    sw_start = 1'b0;
    sw_write = 1'b0;
    sw_addr = 7'h00;
    sw_wdata = 16'h0000;
    ready = 1'b0;
    sig = `SEA_SIG_VALUE;
    for (int i = 0; i < 256; i++)
      {i_sea_eeprom_model.mem[2*i+1], i_sea_eeprom_model.mem[2*i]} = 16'h1111 * i[15:0];
    {i_sea_eeprom_model.mem[1], i_sea_eeprom_model.mem[0]} = sig;
    repeat (16) @(negedge clk);
    check("dch reset", {8'h00, dch}, 16'h0008);
    check("scl reset", {15'h0000, scl}, 16'h0001);
    rst = 1'b0;
    repeat (2000) @(negedge clk);
    check("busy load", {15'h0000, dch[3]}, 16'h0001);
    ready = 1'b1;
    wait_idle(60000);
    check("sig ok", {15'h0000, sig_ok}, 16'h0001);
    check("pulses", 16'(pulses), 16'h000F);
    check("vendor", vid, 16'h1111);
    check("device", did, 16'h2222);
    check("port", pcfg, 16'h3333);
    check("ss vendor", svid, 16'h4444);
    check("ss id", sid, 16'h5555);
    foreach (ROWS[k])
    begin
      sw_go(ROWS[k]);
      check("busy sw", {15'h0000, dch[3]}, 16'h0001);
      wait_idle(8000);
      check("nack", {15'h0000, nack}, 16'h0000);
      if (!ROWS[k].wr)
        check("rdata", rdata, ROWS[k].rdata);
    end
    // start while busy is dropped
    sw_go(ROWS[2]);
    sw_go(ROWS[1]);
    wait_idle(8000);
    check("refused", rdata, 16'h3333);
    repeat (8) @(negedge clk);
    check("no second", {15'h0000, dch[3]}, 16'h0000);
    // bad signature skips the load
    rst = 1'b1;
    i_sea_eeprom_model.mem[0] = ~sig[7:0];
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    wait_idle(8000);
    check("sig bad", {15'h0000, sig_ok}, 16'h0000);
    check("vendor dflt", vid, 16'h0000);
    check("no load", 16'(pulses), 16'h000F);
    final_report;
  end
endmodule

bind sea_top sea_top_assertions i_sea_top_assertions (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .i_link_clk(i_link_clk),
  .o_cfgmem_serial_clock_out(o_cfgmem_serial_clock_out),
  .o_cfgmem_serial_data_out(o_cfgmem_serial_data_out),
  .o_cfgmem_serial_data_oe_n(o_cfgmem_serial_data_oe_n),
  .i_sw_start(i_sw_start),
  .o_cfg_dch(o_cfg_dch),
  .o_sig_ok(o_sig_ok),
  .i_cfg_wr_ready(i_cfg_wr_ready),
  .o_cfg_wr_valid(o_cfg_wr_valid),
  .o_cfg_wr_idx(o_cfg_wr_idx),
  .o_cfg_wr_data(o_cfg_wr_data),
  .o_vendor_id(o_vendor_id),
  .o_port_cfg(o_port_cfg)
);
